// *** hw/cse_pkg.sv ***
// constants and types for the stack and shift execution unit
//
// Operation
// RQ1 - word pop: read top, sp plus 2, write
// RQ2 - byte pop: low byte, register high byte zero
// RQ3 - pop always adds 2 to sp
// RQ4 - push: sp minus 2, then store source
// RQ5 - push always subtracts 2 from sp
// RQ6 - byte push stores byte in low half
// RQ7 - stack ops keep flags unless sr destination
// RQ8 - mode bits kept unless sr destination
// RQ9 - subroutine return: pc from top, sp plus 2
// RQ10 - interrupt return: sr, sp, pc, sp
// RQ11 - interrupt return restores all flags and modes
// RQ12 - left shift: msb to carry, lsb zero
// RQ13 - word overflow for 4000 up to C000
// RQ14 - byte overflow for 40 up to C0
// RQ15 - rotate left inserts old carry at lsb
// RQ16 - shifts set negative and zero from result
// RQ17 - right shift keeps msb, copies it down
// RQ18 - right shift carry from lsb, overflow cleared
// RQ19 - byte right shift clears register high byte
// RQ20 - unkeyed watchdog control write flags violation
package cse_pkg;
   // ----------------------------------------
   // status register layout
   // ----------------------------------------
   localparam int SR_C = 0;
   localparam int SR_Z = 1;
   localparam int SR_N = 2;
   localparam int SR_GIE = 3;
   localparam int SR_CORE_HALT_BIT = 4;
   localparam int SR_OSCILLATOR_OFF_BIT = 5;
   localparam int SR_V = 8;
   localparam logic [15:0] SR_RESET = 16'h0000;
   localparam logic [15:0] SP_RESET = 16'h0000;
   localparam logic [15:0] PC_RESET = 16'h0000;
   localparam logic [15:0] SP_STEP = 16'h0002;
   // ----------------------------------------
   // overflow windows and watchdog
   // ----------------------------------------
   localparam logic [15:0] OVW_LO = 16'h4000;
   localparam logic [15:0] OVW_HI = 16'hC000;
   localparam logic [7:0] OVB_LO = 8'h40;
   localparam logic [7:0] OVB_HI = 8'hC0;
   localparam logic [15:0] WDT_ADDR = 16'h0120;
   localparam logic [7:0] WDT_KEY = 8'h5A;
   // ----------------------------------------
   // operations
   // ----------------------------------------
   typedef enum logic [2:0] {
      CSE_OP_POP = 3'h0,
      CSE_OP_PUSH = 3'h1,
      CSE_OP_SUBRET = 3'h2,
      CSE_OP_IRET = 3'h3,
      CSE_OP_ASL = 3'h4,
      CSE_OP_RLC = 3'h5,
      CSE_OP_ASR = 3'h6
   } cse_op_e;
   // destination kinds
   localparam logic [1:0] DST_REG = 2'h0;
   localparam logic [1:0] DST_MEM = 2'h1;
   localparam logic [1:0] DST_SR = 2'h2;
   localparam logic [1:0] DST_PC = 2'h3;
endpackage

// *** hw/cse_shift.sv ***
// one-position shift and rotate with flag generation
`timescale 1ns/1ps
`default_nettype none
module cse_shift (
   input wire logic [1:0] op,
   input wire logic byte_mode,
   input wire logic carry_in,
   input wire logic [15:0] operand,
   output logic [15:0] result,
   output logic flag_c,
   output logic flag_v,
   output logic flag_n,
   output logic flag_z
);
   wire [15:0] w_asl = {operand[14:0], 1'b0};
   wire [15:0] w_rlc = {operand[14:0], carry_in};
   wire [15:0] w_asr = {operand[15], operand[15:1]};
   wire [7:0] b_asl = {operand[6:0], 1'b0};
   wire [7:0] b_rlc = {operand[6:0], carry_in};
   wire [7:0] b_asr = {operand[7], operand[7:1]};
   wire ovw = (operand >= cse_pkg::OVW_LO) && (operand < cse_pkg::OVW_HI);
   wire ovb = (operand[7:0] >= cse_pkg::OVB_LO) &&
      (operand[7:0] < cse_pkg::OVB_HI);
   wire is_asr = (op == 2'h2);
   wire is_rlc = (op == 2'h1);
   wire [15:0] wres = is_asr ? w_asr : (is_rlc ? w_rlc : w_asl); // RQ12 RQ15 RQ17
   // byte forms clear the upper byte of a register result
   wire [7:0] bres = is_asr ? b_asr : (is_rlc ? b_rlc : b_asl); // RQ19
   assign result = byte_mode ? {8'h00, bres} : wres;
   assign flag_c = is_asr ? operand[0] :
      (byte_mode ? operand[7] : operand[15]); // RQ12 RQ18
   assign flag_v = is_asr ? 1'b0 : (byte_mode ? ovb : ovw); // RQ13 RQ14 RQ18
   assign flag_n = byte_mode ? bres[7] : wres[15]; // RQ16
   assign flag_z = byte_mode ? (bres == 8'h00) : (wres == 16'h0000); // RQ16
endmodule // cse_shift
`default_nettype wire

// *** hw/cse_unit.sv ***
// stack and shift execution unit: sequencer, sp, pc, sr and memory port
`timescale 1ns/1ps
`default_nettype none
module cse_unit (
   input wire logic CLK_SYS,
   input wire logic RSTN,
   input wire logic START,
   input wire logic [2:0] OP,
   input wire logic BYTE_MODE,
   input wire logic [1:0] DST_KIND,
   input wire logic [15:0] DST_ADDR,
   input wire logic [15:0] OPERAND,
   output logic BUSY,
   output logic DONE,
   output logic [15:0] SP,
   output logic [15:0] PC,
   output logic [15:0] SR,
   output logic REG_WE,
   output logic [15:0] REG_WDATA,
   output logic MEM_RD,
   output logic MEM_WR,
   output logic MEM_BYTE,
   output logic [15:0] MEM_ADDR,
   output logic [15:0] MEM_WDATA,
   input wire logic [15:0] MEM_RDATA,
   output logic SEC_VIOLATION
);
   // ----------------------------------------
   // sequencer
   // ----------------------------------------
   typedef enum logic [4:0] {
      CSE_IDLE = 5'h01,
      CSE_RD1 = 5'h02,
      CSE_RD2 = 5'h04,
      CSE_WR = 5'h08,
      CSE_FIN = 5'h10
   } cse_state_e;

   cse_state_e state;
   cse_state_e next_state;
   logic [2:0] op;
   logic byte_mode;
   logic [1:0] dst_kind;
   logic [15:0] dst_addr;
   logic [15:0] operand;
   logic [15:0] tmp;
   logic [15:0] sp;
   logic [15:0] pc;
   logic [15:0] sr;
   logic done;
   logic reg_we;
   logic [15:0] reg_wdata;
   logic mem_rd;
   logic mem_wr;
   logic mem_byte;
   logic [15:0] mem_addr;
   logic [15:0] mem_wdata;
   logic sec_violation;

   wire is_pop = (op == cse_pkg::CSE_OP_POP);
   wire is_push = (op == cse_pkg::CSE_OP_PUSH);
   wire is_sret = (op == cse_pkg::CSE_OP_SUBRET);
   wire is_iret = (op == cse_pkg::CSE_OP_IRET);
   wire is_shift = op[2];
   wire start_ok = START && (state == CSE_IDLE);
   wire [15:0] sp_inc = sp + cse_pkg::SP_STEP;
   wire [15:0] sp_dec = sp - cse_pkg::SP_STEP;

   // ----------------------------------------
   // shifter
   // ----------------------------------------
   wire [15:0] sh_res;
   wire sh_c;
   wire sh_v;
   wire sh_n;
   wire sh_z;
   cse_shift u_shift (
      .op(op[1:0]),
      .byte_mode(byte_mode),
      .carry_in(sr[cse_pkg::SR_C]),
      .operand(operand),
      .result(sh_res),
      .flag_c(sh_c),
      .flag_v(sh_v),
      .flag_n(sh_n),
      .flag_z(sh_z)
   );

   // flags from a shift; mode bits and other sr bits kept
   wire [15:0] sr_shift = {sr[15:9], sh_v, sr[7:3], sh_n, sh_z, sh_c}; // RQ8 RQ16
   // popped data, byte form zero-extended
   wire [15:0] pop_val = byte_mode ? {8'h00, MEM_RDATA[7:0]} : MEM_RDATA; // RQ2
   // result bound for the destination write
   wire [15:0] wr_val = is_shift ? sh_res : tmp;
   wire wr_to_mem = (dst_kind == cse_pkg::DST_MEM);
   // write to the watchdog control word must carry its key in the high byte
   wire wdt_hit = wr_to_mem && (dst_addr == cse_pkg::WDT_ADDR);
   wire wdt_bad = wdt_hit && (byte_mode || wr_val[15:8] != cse_pkg::WDT_KEY); // RQ20
   wire push_wr = is_push; // RQ4

   always_comb begin
      next_state = state;
      case (state)
         CSE_IDLE: begin
            if (START) begin
               next_state = (OP == cse_pkg::CSE_OP_PUSH) ? CSE_WR :
                  (OP[2] ? CSE_WR : CSE_RD1);
            end
         end
         CSE_RD1: begin
            next_state = is_iret ? CSE_RD2 : CSE_WR;
         end
         CSE_RD2: begin
            next_state = CSE_FIN;
         end
         CSE_WR: begin
            next_state = CSE_FIN;
         end
         CSE_FIN: begin
            next_state = CSE_IDLE;
         end
         default: begin
            next_state = CSE_IDLE;
         end
      endcase
   end

   always_ff @(posedge CLK_SYS or negedge RSTN) begin
      if (!RSTN) begin
         state <= CSE_IDLE;
      end else begin
         state <= next_state;
      end
   end

   // operation latch
   always_ff @(posedge CLK_SYS or negedge RSTN) begin
      if (!RSTN) begin
         op <= 3'h0;
         byte_mode <= 1'b0;
         dst_kind <= 2'h0;
         dst_addr <= 16'h0000;
         operand <= 16'h0000;
      end else if (start_ok) begin
         op <= OP;
         byte_mode <= BYTE_MODE;
         dst_kind <= DST_KIND;
         dst_addr <= DST_ADDR;
         operand <= OPERAND;
      end
   end

   // ----------------------------------------
   // memory port, registered outputs
   // ----------------------------------------
   always_ff @(posedge CLK_SYS or negedge RSTN) begin
      if (!RSTN) begin
         mem_rd <= 1'b0;
         mem_wr <= 1'b0;
         mem_byte <= 1'b0;
         mem_addr <= 16'h0000;
         mem_wdata <= 16'h0000;
      end else begin
         mem_rd <= 1'b0;
         mem_wr <= 1'b0;
         mem_byte <= 1'b0;
         if (start_ok && OP != cse_pkg::CSE_OP_PUSH && !OP[2]) begin
            mem_rd <= 1'b1; // RQ1 RQ9 RQ10
            mem_addr <= sp;
         end else if (state == CSE_RD1 && is_iret) begin
            mem_rd <= 1'b1; // RQ10
            // sp rises on this same edge, so address the raised top
            mem_addr <= sp_inc; // RQ10
         end else if (state == CSE_WR && push_wr) begin
            mem_wr <= 1'b1; // RQ4
            mem_addr <= sp;
            mem_wdata <= byte_mode ? {8'h00, operand[7:0]} : operand; // RQ6
         end else if (state == CSE_WR && wr_to_mem) begin
            mem_wr <= 1'b1;
            mem_byte <= byte_mode; // RQ2
            mem_addr <= dst_addr;
            mem_wdata <= wr_val;
         end
      end
   end

   // temp holds the fetched word between read and write
   always_ff @(posedge CLK_SYS or negedge RSTN) begin
      if (!RSTN) begin
         tmp <= 16'h0000;
      end else if (state == CSE_RD1) begin
         tmp <= pop_val; // RQ1
      end
   end

   // ----------------------------------------
   // stack pointer, program counter, status
   // ----------------------------------------
   always_ff @(posedge CLK_SYS or negedge RSTN) begin
      if (!RSTN) begin
         sp <= cse_pkg::SP_RESET;
      end else if (start_ok && OP == cse_pkg::CSE_OP_PUSH) begin
         sp <= sp_dec; // RQ4 RQ5
      end else if (state == CSE_RD1 && !is_push && !is_shift) begin
         sp <= sp_inc; // RQ1 RQ3 RQ9 RQ10
      end else if (state == CSE_RD2) begin
         sp <= sp_inc; // RQ10
      end
   end

   always_ff @(posedge CLK_SYS or negedge RSTN) begin
      if (!RSTN) begin
         pc <= cse_pkg::PC_RESET;
      end else if (state == CSE_RD1 && is_sret) begin
         pc <= MEM_RDATA; // RQ9
      end else if (state == CSE_RD2) begin
         pc <= MEM_RDATA; // RQ10
      end else if (state == CSE_WR && dst_kind == cse_pkg::DST_PC &&
         (is_pop || is_shift)) begin
         pc <= wr_val;
      end
   end

   always_ff @(posedge CLK_SYS or negedge RSTN) begin
      if (!RSTN) begin
         sr <= cse_pkg::SR_RESET;
      end else if (state == CSE_RD1 && is_iret) begin
         sr <= MEM_RDATA; // RQ10 RQ11
      end else if (state == CSE_WR && is_pop &&
         dst_kind == cse_pkg::DST_SR) begin
         sr <= tmp; // RQ7 RQ8
      end else if (state == CSE_WR && is_shift) begin
         sr <= (dst_kind == cse_pkg::DST_SR) ? sh_res : sr_shift; // RQ16 RQ8
      end
   end

   // ----------------------------------------
   // register file write and completion
   // ----------------------------------------
   always_ff @(posedge CLK_SYS or negedge RSTN) begin
      if (!RSTN) begin
         reg_we <= 1'b0;
         reg_wdata <= 16'h0000;
         done <= 1'b0;
         sec_violation <= 1'b0;
      end else begin
         reg_we <= (state == CSE_WR) && (is_pop || is_shift) &&
            (dst_kind == cse_pkg::DST_REG); // RQ2 RQ19
         if (state == CSE_WR) begin
            reg_wdata <= wr_val;
         end
         done <= (next_state == CSE_FIN);
         sec_violation <= (state == CSE_WR) && !is_push && wdt_bad; // RQ20
      end
   end

   assign BUSY = (state != CSE_IDLE);
   assign DONE = done;
   assign SP = sp;
   assign PC = pc;
   assign SR = sr;
   assign REG_WE = reg_we;
   assign REG_WDATA = reg_wdata;
   assign MEM_RD = mem_rd;
   assign MEM_WR = mem_wr;
   assign MEM_BYTE = mem_byte;
   assign MEM_ADDR = mem_addr;
   assign MEM_WDATA = mem_wdata;
   assign SEC_VIOLATION = sec_violation;

   // ----------------------------------------
   // checks
   // ----------------------------------------
   chk_pop_sp_step: assert property (@(posedge CLK_SYS) disable iff (!RSTN) // RQ3
      (state == CSE_RD1 && is_pop) |=> sp == $past(sp) + 16'h0002)
      else $error("pop did not add two to sp");
   chk_push_sp_step: assert property (@(posedge CLK_SYS) disable iff (!RSTN) // RQ5
      (start_ok && OP == cse_pkg::CSE_OP_PUSH) |=> sp == $past(sp) - 16'h0002)
      else $error("push did not take two from sp");
   chk_push_store_addr: assert property (@(posedge CLK_SYS) // RQ4
      disable iff (!RSTN)
      (start_ok && OP == cse_pkg::CSE_OP_PUSH) |=> ##1 (mem_wr && mem_addr == sp))
      else $error("push store not at updated sp");
   chk_iret_sp_total: assert property (@(posedge CLK_SYS) disable iff (!RSTN) // RQ10
      (start_ok && OP == cse_pkg::CSE_OP_IRET) |=> ##2 sp == $past(sp, 3) + 16'h0004)
      else $error("interrupt return sp not plus four");
   chk_iret_sr_load: assert property (@(posedge CLK_SYS) disable iff (!RSTN) // RQ11
      (state == CSE_RD1 && is_iret) |=> sr == $past(MEM_RDATA))
      else $error("interrupt return sr not from stack");
   chk_sret_pc: assert property (@(posedge CLK_SYS) disable iff (!RSTN) // RQ9
      (state == CSE_RD1 && is_sret) |=> pc == $past(MEM_RDATA) && $stable(sr))
      else $error("subroutine return pc or sr wrong");
   chk_stack_flags_kept: assert property (@(posedge CLK_SYS) // RQ7
      disable iff (!RSTN)
      (state != CSE_IDLE && is_push) |=> $stable(sr))
      else $error("push changed status");
   chk_asr_flag_v: assert property (@(posedge CLK_SYS) disable iff (!RSTN) // RQ18
      (state == CSE_WR && op == cse_pkg::CSE_OP_ASR &&
      dst_kind != cse_pkg::DST_SR) |=> !sr[cse_pkg::SR_V] &&
      sr[cse_pkg::SR_C] == $past(operand[0]))
      else $error("right shift carry or overflow wrong");
   chk_byte_pop_high: assert property (@(posedge CLK_SYS) disable iff (!RSTN) // RQ2
      (reg_we && $past(is_pop && byte_mode)) |-> reg_wdata[15:8] == 8'h00)
      else $error("byte pop left upper byte set");
endmodule // cse_unit
`default_nettype wire

// *** verif/tb_top.sv ***
// self-checking bench for the stack and shift execution unit
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   // ----------------------------------------
   // stimulus and observed signals
   // ----------------------------------------
   localparam logic [2:0] O_POP = cse_pkg::CSE_OP_POP;
   localparam logic [2:0] O_PSH = cse_pkg::CSE_OP_PUSH;
   localparam logic [2:0] O_RET = cse_pkg::CSE_OP_SUBRET;
   localparam logic [2:0] O_IRT = cse_pkg::CSE_OP_IRET;
   localparam logic [2:0] O_SL = cse_pkg::CSE_OP_ASL;
   localparam logic [2:0] O_RL = cse_pkg::CSE_OP_RLC;
   localparam logic [2:0] O_SR = cse_pkg::CSE_OP_ASR;
   typedef struct {
      logic [2:0] o;
      logic b;
      logic c;
      logic [15:0] d;
      logic [15:0] r;
      logic [3:0] f;
   } cse_row_s;
   // flags nibble is {v, n, z, c}
   cse_row_s rows [17] = '{
      '{O_SL, 1'b0, 1'b0, 16'h4000, 16'h8000, 4'hC},
      '{O_SL, 1'b0, 1'b1, 16'h3FFF, 16'h7FFE, 4'h0},
      '{O_SL, 1'b0, 1'b0, 16'hC000, 16'h8000, 4'h5},
      '{O_SL, 1'b0, 1'b0, 16'hBFFF, 16'h7FFE, 4'h9},
      '{O_SL, 1'b0, 1'b0, 16'h8000, 16'h0000, 4'hB},
      '{O_SL, 1'b1, 1'b0, 16'h0040, 16'h0080, 4'hC},
      '{O_SL, 1'b1, 1'b0, 16'h00C0, 16'h0080, 4'h5},
      '{O_RL, 1'b0, 1'b1, 16'h8001, 16'h0003, 4'h9},
      '{O_RL, 1'b0, 1'b1, 16'h0000, 16'h0001, 4'h0},
      '{O_RL, 1'b0, 1'b0, 16'h0000, 16'h0000, 4'h2},
      '{O_RL, 1'b1, 1'b0, 16'h0080, 16'h0000, 4'hB},
      '{O_RL, 1'b1, 1'b1, 16'h003F, 16'h007F, 4'h0},
      '{O_SR, 1'b0, 1'b0, 16'h8001, 16'hC000, 4'h5},
      '{O_SR, 1'b0, 1'b1, 16'h0002, 16'h0001, 4'h0},
      '{O_SR, 1'b0, 1'b0, 16'h0001, 16'h0000, 4'h3},
      '{O_SR, 1'b1, 1'b0, 16'hAB81, 16'h00C0, 4'h5},
      '{O_SR, 1'b1, 1'b1, 16'h7F02, 16'h0001, 4'h0}};
   // {violation expected, byte, address, stacked word}
   logic [33:0] wd [4] = '{{1'b0, 1'b0, 16'h0120, 16'h5A80},
      {1'b1, 1'b0, 16'h0120, 16'h1280}, {1'b1, 1'b1, 16'h0120, 16'h5A80},
      {1'b0, 1'b0, 16'h0122, 16'h1280}};
   logic [15:0] iv [2] = '{16'h0139, 16'h0000};
   logic clk = 1'b0;
   logic rstn = 1'b0;
   logic start = 1'b0;
   logic [2:0] op = 3'h0;
   logic bm = 1'b0;
   logic [1:0] dk = 2'h0;
   logic [15:0] da = 16'h0000;
   logic [15:0] opd = 16'h0000;
   logic [15:0] mrdata = 16'h0000;
   logic busy, done, rwe, mrd, mwr, mb, sv;
   logic [15:0] sp, pc, sr, rwd, ma, mwd;
   logic [15:0] rq [$];
   logic [15:0] ra [$];
   logic [32:0] wr;
   logic [15:0] rw, wn, esp, esr;
   logic vseen;
   int err_count = 0;
   int checks = 0;

   cse_unit dut (
      .CLK_SYS(clk), .RSTN(rstn), .START(start), .OP(op), .BYTE_MODE(bm),
      .DST_KIND(dk), .DST_ADDR(da), .OPERAND(opd), .BUSY(busy),
      .DONE(done), .SP(sp), .PC(pc), .SR(sr), .REG_WE(rwe),
      .REG_WDATA(rwd), .MEM_RD(mrd), .MEM_WR(mwr), .MEM_BYTE(mb),
      .MEM_ADDR(ma), .MEM_WDATA(mwd), .MEM_RDATA(mrdata),
      .SEC_VIOLATION(sv));

   initial begin
      forever #4 clk = ~clk;
   end
   // ----------------------------------------
   // memory side: next stacked word stands ahead of each read
   // ----------------------------------------
   // the unit takes read data in the cycle of its read pulse
   always @(posedge clk) begin
      if (mrd === 1'b1 && rq.size() > 0)
         rq.delete(0);
      if (rq.size() > 0)
         mrdata <= rq[0];
      else
         mrdata <= ~mrdata;
   end
   // pulses stand one cycle, so capture them mid-cycle
   always @(negedge clk) begin
      if (mrd === 1'b1)
         ra.push_back(ma);
      if (mwr === 1'b1)
         wr = {mb, ma, mwd};
      if (mwr === 1'b1)
         wn = wn + 16'h0001;
      if (rwe === 1'b1)
         rw = rwd;
      if (sv === 1'b1)
         vseen = 1'b1;
   end
   // ----------------------------------------
   // tasks
   // ----------------------------------------
   task automatic fail(input string m);
      err_count++;
      $display("mismatch at %0t: %s", $time, m);
   endtask
   task automatic chk16(input logic [15:0] g, e, input string m);
      checks++;
      if (g !== e)
         fail($sformatf("%s got %h want %h", m, g, e));
   endtask
   task automatic chk1(input logic g, e, input string m);
      checks++;
      if (g !== e)
         fail($sformatf("%s got %b want %b", m, g, e));
   endtask
   task automatic conclude();
      $display("checks %0d mismatches %0d", checks, err_count);
      if (err_count == 0 && checks > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask
   // one operation; returns one edge after done, when the unit is idle
   task automatic run(input logic [2:0] o, input logic b,
         input logic [1:0] k, input logic [15:0] a, d);
      int n;
      ra.delete();
      wr = 'x;
      rw = 'x;
      wn = 16'h0000;
      vseen = 1'b0;
      @(posedge clk);
      start <= 1'b1;
      op <= o;
      bm <= b;
      dk <= k;
      da <= a;
      opd <= d;
      @(posedge clk);
      start <= 1'b0;
      n = 0;
      while (done !== 1'b1) begin
         @(negedge clk);
         n++;
         if (n > 12) begin
            fail("done never came");
            conclude();
         end
      end
      @(posedge clk);
   endtask
   task automatic pop(input logic [15:0] w, input logic b,
         input logic [1:0] k, input logic [15:0] a);
      rq.push_back(w);
      run(O_POP, b, k, a, 16'h0000);
      chk16(ra[0], esp, "pop read address");
      esp = esp + 16'h0002;
      chk16(sp, esp, "pop sp");
   endtask
   // ----------------------------------------
   // main sequence
   // ----------------------------------------
   initial begin
      repeat (10) @(posedge clk);
      rstn <= 1'b1;
      @(negedge clk);
      chk16(sp, cse_pkg::SP_RESET, "sp reset");
      chk16(pc, cse_pkg::PC_RESET, "pc reset");
      chk16(sr, cse_pkg::SR_RESET, "sr reset");
      chk1(busy, 1'b0, "busy reset");
      esp = cse_pkg::SP_RESET;
      $display("test reset done");
      foreach (rows[i]) begin
         esr = 16'h0038 | {15'h0000, rows[i].c};
         pop(esr, 1'b0, cse_pkg::DST_SR, 16'h0000);
         chk16(sr, esr, "sr loaded by pop");
         run(rows[i].o, rows[i].b, cse_pkg::DST_REG, 16'h0000, rows[i].d);
         chk16(rw, rows[i].r, "shift result");
         esr = {7'h00, rows[i].f[3], 2'b00, 3'b111, rows[i].f[2:0]};
         chk16(sr, esr, "shift flags");
      end
      chk16(sp, esp, "sp after shifts");
      run(O_SL, 1'b1, cse_pkg::DST_MEM, 16'h0300, 16'h0041);
      chk16(wr[31:16], 16'h0300, "shift store address");
      chk16(wr[15:0], 16'h0082, "shift store data");
      chk1(wr[32], 1'b1, "shift store width");
      esr = 16'h013C;
      chk16(sr, esr, "shift store flags");
      $display("test shift table done");
      run(O_PSH, 1'b0, cse_pkg::DST_MEM, 16'h0000, 16'h1234);
      esp = esp - 16'h0002;
      chk16(sp, esp, "push sp");
      chk16(wr[31:16], esp, "push address");
      chk16(wr[15:0], 16'h1234, "push data");
      run(O_PSH, 1'b1, cse_pkg::DST_MEM, 16'h0000, 16'hABCD);
      esp = esp - 16'h0002;
      chk16(sp, esp, "byte push sp");
      chk16(wr[31:16], esp, "byte push address");
      chk16(wr[15:0], 16'h00CD, "byte push data");
      chk16(sr, esr, "sr after push");
      $display("test push done");
      pop(16'hBEEF, 1'b0, cse_pkg::DST_REG, 16'h0000);
      chk16(rw, 16'hBEEF, "word pop");
      pop(16'hBEEF, 1'b1, cse_pkg::DST_REG, 16'h0000);
      chk16(rw, 16'h00EF, "byte pop register");
      pop(16'h1234, 1'b1, cse_pkg::DST_MEM, 16'h0200);
      chk16(wr[31:16], 16'h0200, "byte pop address");
      chk16({8'h00, wr[7:0]}, 16'h0034, "byte pop data");
      chk1(wr[32], 1'b1, "byte pop width");
      chk16(sr, esr, "sr after pop");
      pop(16'h2468, 1'b0, cse_pkg::DST_PC, 16'h0000);
      chk16(pc, 16'h2468, "pop to pc");
      $display("test pop done");
      rq.push_back(16'h4466);
      run(O_RET, 1'b0, cse_pkg::DST_REG, 16'h0000, 16'h0000);
      chk16(ra[0], esp, "return read address");
      esp = esp + 16'h0002;
      chk16(sp, esp, "return sp");
      chk16(pc, 16'h4466, "return pc");
      chk16(wn, 16'h0000, "return writes");
      chk16(sr, esr, "return sr");
      $display("test subroutine return done");
      foreach (iv[i]) begin
         rq.push_back(iv[i]);
         rq.push_back(16'h8A00 + iv[i]);
         run(O_IRT, 1'b0, cse_pkg::DST_REG, 16'h0000, 16'h0000);
         chk16(ra[0], esp, "first read");
         chk16(ra[1], esp + 16'h0002, "second read");
         esp = esp + 16'h0004;
         chk16(sp, esp, "iret sp");
         chk16(sr, iv[i], "iret sr");
         chk16(pc, 16'h8A00 + iv[i], "iret pc");
         chk16(wn, 16'h0000, "iret writes");
      end
      $display("test interrupt return done");
      foreach (wd[i]) begin
         pop(wd[i][15:0], wd[i][32], cse_pkg::DST_MEM, wd[i][31:16]);
         chk1(vseen, wd[i][33], "watchdog violation");
      end
      $display("test watchdog done");
      conclude();
   end
endmodule // tb_top
`default_nettype wire
